// ==== wdcg_pkg.sv ====
/*
 * wdcg_pkg: constants and types of the watchdog control guard block.
 * assumes a 32-bit axi4-lite bus; register index times four gives the byte address.
 */
package wdcg_pkg;

    // --------------------------------------------------------------
    // bus
    // --------------------------------------------------------------
    localparam int AXI_AW = 18;
    localparam int AXI_DW = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // --------------------------------------------------------------
    // register indexes (byte address = index * 4)
    // --------------------------------------------------------------
    localparam logic [15:0] CTRL_IDX = 16'hffb1;
    localparam logic [15:0] CNT_IDX = 16'hffb2;
    localparam logic [15:0] IRQ_STAT_IDX = 16'hffb3;
    localparam logic [15:0] IRQ_MASK_IDX = 16'hffb4;

    // --------------------------------------------------------------
    // control/status field positions
    // --------------------------------------------------------------
    localparam int CTRL_CNT_GUARD = 7;
    localparam int CTRL_CNT_WE = 6;
    localparam int CTRL_WE_GUARD = 5;
    localparam int CTRL_WE = 4;
    localparam int CTRL_RUN_GUARD = 3;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_FLAG_GUARD = 1;
    localparam int CTRL_FLAG = 0;
    localparam int IRQ_OVF = 0;

    // --------------------------------------------------------------
    // widths and reset values
    // --------------------------------------------------------------
    localparam int CNT_W = 8;
    localparam logic CTRL_BIT_RST = 1'h0;
    localparam logic IRQ_MASK_RST = 1'h0;

    typedef struct packed {
        logic cntWe;
        logic ctrlWe;
        logic run;
        logic flag;
    } wdcg_ctrl_t;

endpackage

// ==== wdcg_counter.sv ====
/*
 * wdcg_counter: the up-counting watchdog counter with load and overflow pulse.
 * assumes load and intRst come from logic on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module wdcg_counter #(
    parameter int CNT_W = wdcg_pkg::CNT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic intRst,
    input wire logic run,
    input wire logic load,
    input wire logic [CNT_W-1:0] loadValue,
    output logic [CNT_W-1:0] count_r,
    output logic ovf_r
);

    if (CNT_W < 2 || CNT_W > 32)
    begin : g_chk
        $error("wdcg_counter: CNT_W must be 2..32");
    end

    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    // --------------------------------------------------------------
    // counting
    // --------------------------------------------------------------
    // internal reset wins over a load in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (rst || intRst)
            count_r <= '0;
        else if (load)
            count_r <= loadValue;
        else if (run)
            count_r <= count_r + 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ovf_r <= 1'b0;
        else
            ovf_r <= run && !load && !intRst && (count_r == CNT_MAX);
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_count_up;
        run && !load && !intRst |=> count_r == CNT_W'($past(count_r) + 1'b1);
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step");

    property p_count_hold;
        !run && !load && !intRst |=> $stable(count_r) && !ovf_r;
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved while stopped");

endmodule

`default_nettype wire

// ==== wdcg_top.sv ====
/*
 * wdcg_top: watchdog control/status register with write guards, counter,
 * overflow-reset flag, interrupt status and mask, behind an axi4-lite slave.
 * assumes a single synchronous reset from the reset pin and one clock.
 */
// Function
// - the counter write-enable bit changes only when the same write has 0 in its guard bit, which reads 1, or on counter overflow, which clears it.
// - counter writes load the counter only while the counter write-enable bit is 1.
// - the control write-enable bit changes only when the same write has 0 in its guard bit, which reads 1, or on counter overflow, which clears it.
// - the run bit and the overflow flag take writes only while the control write-enable bit is 1.
// - the run bit changes only when the same write has 0 in its guard bit, which reads 1, or on counter overflow, which clears it.
// - the counter counts up while the run bit is 1 and holds while it is 0.
// - a gated write with guard 0 and run 1 sets the run bit.
// - a gated write with guard 0 and run 0 clears the run bit.
// - the overflow flag changes only when the same write has 0 in its guard bit, which reads 1, or on counter overflow, which sets it.
// - counter overflow raises an internal reset and sets the flag, which survives that reset.
// - the reset pin clears the overflow flag.
// - a gated write with 0 in the flag and its guard clears the flag.
`timescale 1ns/1ps
`default_nettype none

module wdcg_top #(
    parameter int CNT_W = wdcg_pkg::CNT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [wdcg_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [wdcg_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [wdcg_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [wdcg_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic wdtReset
);

    if (CNT_W < 2 || CNT_W > wdcg_pkg::AXI_DW)
    begin : g_chk
        $error("wdcg_top: CNT_W must be 2..32");
    end

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    function automatic logic isAt(input logic [wdcg_pkg::AXI_AW-1:0] addr,
                                  input logic [15:0] idx);
        isAt = (addr[wdcg_pkg::AXI_AW-1:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic isMapped(input logic [wdcg_pkg::AXI_AW-1:0] addr);
        isMapped = isAt(addr, wdcg_pkg::CTRL_IDX) || isAt(addr, wdcg_pkg::CNT_IDX) ||
                   isAt(addr, wdcg_pkg::IRQ_STAT_IDX) || isAt(addr, wdcg_pkg::IRQ_MASK_IDX);
    endfunction

    logic [wdcg_pkg::AXI_AW-1:0] awAddr_r;
    logic [wdcg_pkg::AXI_DW-1:0] wData_r;
    logic [3:0] wStrb_r;
    logic awHeld_r;
    logic wHeld_r;
    logic bvalid_r;
    logic awReady_r;
    logic wReady_r;
    logic [1:0] bResp_r;
    logic arReady_r;
    logic rvalid_r;
    logic [wdcg_pkg::AXI_DW-1:0] rData_r;
    logic [1:0] rResp_r;
    logic [wdcg_pkg::AXI_DW-1:0] rdNxt;
    wdcg_pkg::wdcg_ctrl_t ctrl_r;
    logic irqStat_r;
    logic irqMask_r;
    logic irq_r;
    logic intRst_r;
    logic [CNT_W-1:0] count;
    logic cntOvf;
    logic wrFire;
    logic wrCtrl;
    logic wrCnt;
    logic cntLoad;

    // --------------------------------------------------------------
    // write channels
    // --------------------------------------------------------------
    // address and data are held separately so either may come first
    assign wrFire = awHeld_r && wHeld_r && !bvalid_r;
    assign wrCtrl = wrFire && isAt(awAddr_r, wdcg_pkg::CTRL_IDX) && wStrb_r[0];
    assign wrCnt = wrFire && isAt(awAddr_r, wdcg_pkg::CNT_IDX) && wStrb_r[0];
    assign cntLoad = wrCnt && ctrl_r.cntWe;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            awReady_r <= 1'b0;
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
        end
        else if (s_axi_awvalid && awReady_r)
        begin
            awReady_r <= 1'b0;
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end
        else
        begin
            if (wrFire)
                awHeld_r <= 1'b0;
            if (!awHeld_r && !bvalid_r && !wrFire)
                awReady_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wReady_r <= 1'b0;
            wHeld_r <= 1'b0;
            wData_r <= '0;
            wStrb_r <= 4'h0;
        end
        else if (s_axi_wvalid && wReady_r)
        begin
            wReady_r <= 1'b0;
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end
        else
        begin
            if (wrFire)
                wHeld_r <= 1'b0;
            if (!wHeld_r && !bvalid_r && !wrFire)
                wReady_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bvalid_r <= 1'b0;
            bResp_r <= wdcg_pkg::RESP_OKAY;
        end
        else if (wrFire)
        begin
            bvalid_r <= 1'b1;
            bResp_r <= isMapped(awAddr_r) ? wdcg_pkg::RESP_OKAY : wdcg_pkg::RESP_SLVERR;
        end
        else if (bvalid_r && s_axi_bready)
            bvalid_r <= 1'b0;
    end

    // --------------------------------------------------------------
    // read channel
    // --------------------------------------------------------------
    always_comb
    begin
        rdNxt = '0;
        if (isAt(s_axi_araddr, wdcg_pkg::CTRL_IDX))
        begin
            rdNxt[wdcg_pkg::CTRL_CNT_GUARD] = 1'b1;
            rdNxt[wdcg_pkg::CTRL_CNT_WE] = ctrl_r.cntWe;
            rdNxt[wdcg_pkg::CTRL_WE_GUARD] = 1'b1;
            rdNxt[wdcg_pkg::CTRL_WE] = ctrl_r.ctrlWe;
            rdNxt[wdcg_pkg::CTRL_RUN_GUARD] = 1'b1;
            rdNxt[wdcg_pkg::CTRL_RUN] = ctrl_r.run;
            rdNxt[wdcg_pkg::CTRL_FLAG_GUARD] = 1'b1;
            rdNxt[wdcg_pkg::CTRL_FLAG] = ctrl_r.flag;
        end
        else if (isAt(s_axi_araddr, wdcg_pkg::CNT_IDX))
            rdNxt[CNT_W-1:0] = count;
        else if (isAt(s_axi_araddr, wdcg_pkg::IRQ_STAT_IDX))
            rdNxt[wdcg_pkg::IRQ_OVF] = irqStat_r;
        else if (isAt(s_axi_araddr, wdcg_pkg::IRQ_MASK_IDX))
            rdNxt[wdcg_pkg::IRQ_OVF] = irqMask_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            arReady_r <= 1'b0;
            rvalid_r <= 1'b0;
            rData_r <= '0;
            rResp_r <= wdcg_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && arReady_r)
        begin
            arReady_r <= 1'b0;
            rvalid_r <= 1'b1;
            rData_r <= rdNxt;
            rResp_r <= isMapped(s_axi_araddr) ? wdcg_pkg::RESP_OKAY : wdcg_pkg::RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
        else if (!rvalid_r)
            arReady_r <= 1'b1;
    end

    // --------------------------------------------------------------
    // guarded control/status bits
    // --------------------------------------------------------------
    // overflow has priority: the internal reset must not be undone by a write
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_r.cntWe <= wdcg_pkg::CTRL_BIT_RST;
            ctrl_r.ctrlWe <= wdcg_pkg::CTRL_BIT_RST;
            ctrl_r.run <= wdcg_pkg::CTRL_BIT_RST;
            ctrl_r.flag <= wdcg_pkg::CTRL_BIT_RST;
        end
        else if (cntOvf)
        begin
            ctrl_r.cntWe <= 1'b0;
            ctrl_r.ctrlWe <= 1'b0;
            ctrl_r.run <= 1'b0;
            ctrl_r.flag <= 1'b1;
        end
        else if (wrCtrl)
        begin
            if (!wData_r[wdcg_pkg::CTRL_CNT_GUARD])
                ctrl_r.cntWe <= wData_r[wdcg_pkg::CTRL_CNT_WE];
            if (!wData_r[wdcg_pkg::CTRL_WE_GUARD])
                ctrl_r.ctrlWe <= wData_r[wdcg_pkg::CTRL_WE];
            // old ctrlWe value: a write cannot unlock itself
            if (ctrl_r.ctrlWe)
            begin
                if (!wData_r[wdcg_pkg::CTRL_RUN_GUARD])
                    ctrl_r.run <= wData_r[wdcg_pkg::CTRL_RUN];
                if (!wData_r[wdcg_pkg::CTRL_FLAG_GUARD] && !wData_r[wdcg_pkg::CTRL_FLAG])
                    ctrl_r.flag <= 1'b0;
            end
        end
    end

    // internal reset pulse; it clears the counter but not the flag
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            intRst_r <= 1'b0;
        else
            intRst_r <= cntOvf;
    end

    wdcg_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .sys_clk(sys_clk),
        .rst(rst),
        .intRst(intRst_r),
        .run(ctrl_r.run),
        .load(cntLoad),
        .loadValue(wData_r[CNT_W-1:0]),
        .count_r(count),
        .ovf_r(cntOvf)
    );

    // --------------------------------------------------------------
    // interrupt
    // --------------------------------------------------------------
    // set wins over a same-cycle write-one clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irqStat_r <= 1'b0;
        else if (cntOvf)
            irqStat_r <= 1'b1;
        else if (wrFire && isAt(awAddr_r, wdcg_pkg::IRQ_STAT_IDX) && wStrb_r[0] &&
                 wData_r[wdcg_pkg::IRQ_OVF])
            irqStat_r <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irqMask_r <= wdcg_pkg::IRQ_MASK_RST;
        else if (wrFire && isAt(awAddr_r, wdcg_pkg::IRQ_MASK_IDX) && wStrb_r[0])
            irqMask_r <= wData_r[wdcg_pkg::IRQ_OVF];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_r <= 1'b0;
        else
            irq_r <= irqStat_r && irqMask_r;
    end

    assign s_axi_awready = awReady_r;
    assign s_axi_wready = wReady_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;
    assign irq = irq_r;
    assign wdtReset = intRst_r;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_cnt_we_guard;
        $changed(ctrl_r.cntWe) && !$past(cntOvf) |->
            $past(wrCtrl) && !$past(wData_r[wdcg_pkg::CTRL_CNT_GUARD]);
    endproperty
    a_cnt_we_guard: assert property (p_cnt_we_guard) else $error("cntWe changed unguarded");

    property p_load;
        wrCnt && ctrl_r.cntWe && !intRst_r |=> count == $past(wData_r[CNT_W-1:0]);
    endproperty
    a_load: assert property (p_load) else $error("counter not loaded");

    property p_no_load;
        wrCnt && !ctrl_r.cntWe && !ctrl_r.run && !intRst_r |=> $stable(count);
    endproperty
    a_no_load: assert property (p_no_load) else $error("locked counter loaded");

    property p_ctrl_we_guard;
        $changed(ctrl_r.ctrlWe) && !$past(cntOvf) |->
            $past(wrCtrl) && !$past(wData_r[wdcg_pkg::CTRL_WE_GUARD]);
    endproperty
    a_ctrl_we_guard: assert property (p_ctrl_we_guard) else $error("ctrlWe changed unguarded");

    property p_run_gate;
        $changed(ctrl_r.run) && !$past(cntOvf) |->
            $past(wrCtrl) && $past(ctrl_r.ctrlWe) && !$past(wData_r[wdcg_pkg::CTRL_RUN_GUARD]);
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("run changed ungated");

    property p_run_set;
        wrCtrl && ctrl_r.ctrlWe && !cntOvf && !wData_r[wdcg_pkg::CTRL_RUN_GUARD] &&
            wData_r[wdcg_pkg::CTRL_RUN] |=> ctrl_r.run;
    endproperty
    a_run_set: assert property (p_run_set) else $error("run not set");

    property p_run_clr;
        wrCtrl && ctrl_r.ctrlWe && !cntOvf && !wData_r[wdcg_pkg::CTRL_RUN_GUARD] &&
            !wData_r[wdcg_pkg::CTRL_RUN] |=> !ctrl_r.run;
    endproperty
    a_run_clr: assert property (p_run_clr) else $error("run not cleared");

    property p_flag_gate;
        $fell(ctrl_r.flag) |->
            $past(wrCtrl) && $past(ctrl_r.ctrlWe) && !$past(wData_r[wdcg_pkg::CTRL_FLAG_GUARD]);
    endproperty
    a_flag_gate: assert property (p_flag_gate) else $error("flag cleared ungated");

    property p_ovf_reset;
        cntOvf |=> ctrl_r.flag && intRst_r && !ctrl_r.run ##1 ctrl_r.flag && count == '0;
    endproperty
    a_ovf_reset: assert property (p_ovf_reset) else $error("overflow reset wrong");

    property p_pin_clear;
        @(posedge sys_clk) disable iff (1'b0) rst |=> !ctrl_r.flag && !wdtReset;
    endproperty
    a_pin_clear: assert property (p_pin_clear) else $error("reset pin left flag set");

    property p_flag_clr;
        wrCtrl && ctrl_r.ctrlWe && !cntOvf &&
            wData_r[wdcg_pkg::CTRL_FLAG_GUARD:wdcg_pkg::CTRL_FLAG] == 2'h0 |=> !ctrl_r.flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

    property p_no_self_unlock;
        wrCtrl && !ctrl_r.ctrlWe && !cntOvf |=> $stable(ctrl_r.run) && $stable(ctrl_r.flag);
    endproperty
    a_no_self_unlock: assert property (p_no_self_unlock) else $error("write unlocked itself");

    c_load: cover property (cntLoad);
    c_overflow: cover property (cntOvf ##2 irq);
    c_run_start: cover property ($rose(ctrl_r.run));
    c_flag_clear: cover property ($fell(ctrl_r.flag));

endmodule

`default_nettype wire

// ==== wdcg_done.sv ====
/*
 * wdcg_done: intentionally empty compile unit marker; holds no logic.
 * assumes nothing.
 */

// ==== watchdog_control_guard_bench.sv ====
/*
 * watchdog_control_guard_bench: register-level bench of the watchdog control guard.
 * assumes wdcg_pkg and the design files are compiled first; one clock, sync reset.
 */
`timescale 1ns/1ps
`default_nettype none

module watchdog_control_guard_bench;

    // --------------------------------------------------------------
    // stimulus signals
    // --------------------------------------------------------------
    localparam logic [17:0] A_CTRL = {wdcg_pkg::CTRL_IDX, 2'h0};
    localparam logic [17:0] A_CNT = {wdcg_pkg::CNT_IDX, 2'h0};
    localparam logic [17:0] A_STAT = {wdcg_pkg::IRQ_STAT_IDX, 2'h0};
    localparam logic [17:0] A_MASK = {wdcg_pkg::IRQ_MASK_IDX, 2'h0};
    localparam logic [1:0] OK = wdcg_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = wdcg_pkg::RESP_SLVERR;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [17:0] s_axi_awaddr = 18'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'h1;
    logic [17:0] s_axi_araddr = 18'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'h1;
    logic irq;
    logic wdtReset;
    int n_errors = 0;
    int comparisons = 0;
    logic [31:0] cntA;
    logic [31:0] cntB;

    wdcg_top dut_u (
        .sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq), .wdtReset(wdtReset)
    );

    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    // --------------------------------------------------------------
    // bus tasks
    // --------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bready stays high throughout, so back-to-back calls never drive it twice in a step
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awPend;
        logic wPend;
        int t;
        awPend = 1'h1;
        wPend = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        for (t = 0; t < 200; t++)
        begin
            @(posedge sys_clk);
            if (awPend && s_axi_awready === 1'h1)
            begin
                awPend = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (wPend && s_axi_wready === 1'h1)
            begin
                wPend = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
            if (s_axi_bvalid === 1'h1)
                break;
        end
        chk("write answered", 32'h1, {31'h0, t < 200});
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [17:0] a, input logic [1:0] er, output logic [31:0] d);
        logic arPend;
        int t;
        arPend = 1'h1;
        d = 32'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        for (t = 0; t < 200; t++)
        begin
            @(posedge sys_clk);
            if (arPend && s_axi_arready === 1'h1)
            begin
                arPend = 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (s_axi_rvalid === 1'h1)
                break;
        end
        d = s_axi_rdata;
        chk("read answered", 32'h1, {31'h0, t < 200});
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    task automatic rdc(input string what, input logic [17:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, OK, d);
        chk(what, exp, d);
    endtask

    // counter is loaded with run off, so the overflow cannot slip past the wait
    task automatic overflow_from(input logic [7:0] v);
        int t;
        wr(A_CTRL, 32'h50, OK);
        wr(A_CNT, {24'h0, v}, OK);
        wr(A_CTRL, 32'h94, OK);
        for (t = 0; t < 300; t++)
        begin
            @(posedge sys_clk);
            if (wdtReset === 1'h1)
                break;
        end
        chk("wdt reset seen", 32'h1, {31'h0, t < 300});
        @(posedge sys_clk);
        chk("wdt reset pulse", 32'h0, {31'h0, wdtReset});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        rdc("ctrl reset", A_CTRL, 32'haa);
        wr(A_CTRL, 32'hff, OK);
        rdc("ctrl guarded", A_CTRL, 32'haa);
        wr(A_CNT, 32'h33, OK);
        rdc("count locked", A_CNT, 32'h0);
        wr(A_CTRL, 32'h40, OK);
        rdc("cnt we set", A_CTRL, 32'hea);
        wr(A_CNT, 32'h55, OK);
        rdc("count loaded", A_CNT, 32'h55);
        $display("test guards and load done");
        wr(A_CTRL, 32'h94, OK);
        rdc("ctrl we only", A_CTRL, 32'hfa);
        rdc("count held", A_CNT, 32'h55);
        wr(A_CTRL, 32'h94, OK);
        rdc("run set", A_CTRL, 32'hfe);
        rd(A_CNT, OK, cntA);
        rd(A_CNT, OK, cntB);
        chk("count moves", 32'h1, {31'h0, cntA !== cntB});
        wr(A_CTRL, 32'h90, OK);
        rdc("run cleared", A_CTRL, 32'hfa);
        rd(A_CNT, OK, cntA);
        repeat (10) @(posedge sys_clk);
        rd(A_CNT, OK, cntB);
        chk("count stopped", cntA, cntB);
        $display("test run control done");
        wr(A_MASK, 32'h1, OK);
        overflow_from(8'hf0);
        rdc("flag after ovf", A_CTRL, 32'hab);
        rdc("count after ovf", A_CNT, 32'h0);
        rdc("irq status", A_STAT, 32'h1);
        chk("irq up", 32'h1, {31'h0, irq});
        wr(A_MASK, 32'h0, OK);
        repeat (2) @(posedge sys_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(A_MASK, 32'h1, OK);
        repeat (2) @(posedge sys_clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(A_STAT, 32'h1, OK);
        rdc("irq status cleared", A_STAT, 32'h0);
        chk("irq down", 32'h0, {31'h0, irq});
        $display("test overflow and irq done");
        wr(A_CTRL, 32'h00, OK);
        rdc("flag kept", A_CTRL, 32'hab);
        wr(A_CTRL, 32'h10, OK);
        rdc("ctrl we again", A_CTRL, 32'hbb);
        wr(A_CTRL, 32'h12, OK);
        rdc("flag guarded", A_CTRL, 32'hbb);
        wr(A_CTRL, 32'h10, OK);
        rdc("flag cleared", A_CTRL, 32'hba);
        overflow_from(8'hf8);
        rdc("flag again", A_CTRL, 32'hab);
        rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        rdc("flag after pin reset", A_CTRL, 32'haa);
        // low byte strobe off: the write must leave the guarded bits alone
        s_axi_wstrb <= 4'he;
        wr(A_CTRL, 32'h40, OK);
        s_axi_wstrb <= 4'hf;
        rdc("ctrl strobe off", A_CTRL, 32'haa);
        $display("test flag clearing done");
        rd(18'h3ffd4, ERR, cntA);
        rd(18'h3ffc5, ERR, cntA);
        wr(18'h3ffd4, 32'hff, ERR);
        rdc("ctrl after bad write", A_CTRL, 32'haa);
        $display("test unmapped done");
        tally_and_finish;
    end

    // the tests take a few hundred cycles; this span is dozens of times that
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        tally_and_finish;
    end

endmodule

`default_nettype wire
